// >>> rtl/guard_lock_fault_monitor.v
`timescale 1ns/1ps
`include "guard_lock_defs.vh"


// ====================================================================
module guard_lock_fault_monitor #(
  parameter [39:0] ESCALATE_CYCLES = `ESCALATE_CYCLES,
  parameter [31:0] FLASH_HALF      = `FLASH_HALF_CYCLES
) (
  input  wire               ref_clk,                   // 40 MHz clock
  input  wire               rst_n,                     // Sync reset
  input  wire               clk_en,                    // Clock enable
  input  wire               guard_closed,              // Guard sensor
  input  wire               guard_locked,              // Lock engaged
  input  wire               lock_possible,             // Turret at rest
  input  wire               upstream_safety_in_first,  // Upstream ch 1
  input  wire               upstream_safety_in_second, // Upstream ch 2
  input  wire [`SRC_W-1:0]  fault_src,                 // Fault sources
  output reg                safety_out_first,          // Safety out 1
  output reg                safety_out_second,         // Safety out 2
  output reg                diag_out,                  // Diagnostic out
  output reg                led_green,                 // Power lamp
  output reg                led_yellow,                // Status lamp
  output reg                led_red                    // Fault lamp
);

  // ==================================================================
  // Input synchronisers, all inputs arrive from pins
  localparam NIN = 5 + `SRC_W;
  reg  [NIN-1:0] sync_a;
  reg  [NIN-1:0] sync_b;

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      sync_a <= {NIN{1'b0}};
      sync_b <= {NIN{1'b0}};
    end else if (clk_en) begin
      sync_a <= {fault_src, upstream_safety_in_second,
                 upstream_safety_in_first, lock_possible,
                 guard_locked, guard_closed};
      sync_b <= sync_a;
    end
  end

  wire              g_closed = sync_b[0];
  wire              g_locked = sync_b[1] & sync_b[0];
  wire              l_poss   = sync_b[2];
  wire              up_ok    = sync_b[3] & sync_b[4];
  wire [`SRC_W-1:0] src      = sync_b[NIN-1:5];

  // ==================================================================
  // Fault classification
  wire warn_out1  = src[`SRC_OUT_FIRST]  & ~src[`SRC_OUT_SECOND];
  wire warn_out2  = src[`SRC_OUT_SECOND] & ~src[`SRC_OUT_FIRST];
  wire warn_cross = src[`SRC_CROSS] |
                    (src[`SRC_OUT_FIRST] & src[`SRC_OUT_SECOND]);
  wire warn_temp  = src[`SRC_TEMP];
  wire warn_any   = warn_out1 | warn_out2 | warn_cross | warn_temp;

  // Highest code wins when several warnings coexist
  reg [2:0] warn_code;
  always @* begin
    if (warn_temp)
      warn_code = `CODE_TEMP;
    else if (warn_cross)
      warn_code = `CODE_CROSS;
    else if (warn_out2)
      warn_code = `CODE_OUT_SECOND;
    else if (warn_out1)
      warn_code = `CODE_OUT_FIRST;
    else
      warn_code = `CODE_NONE;
  end

  // ==================================================================
  // Latched error state
  reg        err_latched;
  reg [2:0]  err_code;
  reg        err_internal;
  reg        err_seen_open;
  reg [39:0] warn_timer;
  reg        g_closed_d;

  wire escalate = warn_any && (warn_timer == ESCALATE_CYCLES - 40'h1);

  reg [2:0] new_code;
  reg       new_err;
  always @* begin
    new_err  = 1'b1;
    new_code = `CODE_NONE;
    if (src[`SRC_INTERNAL])
      new_code = `CODE_NONE;
    else if (src[`SRC_HANDLE])
      new_code = `CODE_HANDLE;
    else if (src[`SRC_ACTUATOR])
      new_code = `CODE_ACTUATOR;
    else if (escalate)
      new_code = warn_code;
    else
      new_err = 1'b0;
  end

  // Cause must be absent when the guard recloses after opening
  wire cause_gone = ~src[`SRC_INTERNAL] & ~src[`SRC_HANDLE] &
                    ~src[`SRC_ACTUATOR] & ~warn_any;

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      err_latched   <= 1'b0;
      err_code      <= `CODE_NONE;
      err_internal  <= 1'b0;
      err_seen_open <= 1'b0;
      warn_timer    <= 40'h0;
      g_closed_d    <= 1'b0;
    end else if (clk_en) begin
      g_closed_d <= g_closed;
      // Timer restarts whenever the warning drops, even briefly
      if (!warn_any || err_latched)
        warn_timer <= 40'h0;
      else if (!escalate)
        warn_timer <= warn_timer + 40'h1;
      if (new_err && !err_latched) begin
        err_latched   <= 1'b1;
        err_code      <= new_code;
        err_internal  <= src[`SRC_INTERNAL];
        err_seen_open <= 1'b0;
      end else if (err_latched) begin
        if (!g_closed)
          err_seen_open <= 1'b1;
        // Fresh fault while latched restarts the open-close demand
        if (new_err)
          err_seen_open <= 1'b0;
        else if (err_seen_open && g_closed && !g_closed_d &&
                 cause_gone) begin
          err_latched   <= 1'b0;
          err_code      <= `CODE_NONE;
          err_internal  <= 1'b0;
          err_seen_open <= 1'b0;
        end
      end
    end
  end

  // ==================================================================
  // Yellow and green slow blink, 1 Hz
  reg [31:0] blink_tick;
  reg        blink;
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      blink_tick <= 32'h0;
      blink      <= 1'b0;
    end else if (clk_en) begin
      if (blink_tick == FLASH_HALF * 32'h2 - 32'h1) begin
        blink_tick <= 32'h0;
        blink      <= ~blink;
      end else begin
        blink_tick <= blink_tick + 32'h1;
      end
    end
  end

  // ==================================================================
  // Red pulse code
  wire [2:0] flash_code = err_latched ? err_code : warn_code;
  wire       red_flash;

  pulse_code_flasher #(
    .HALF_CYCLES (FLASH_HALF)
  ) u_red_flasher (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .code    (err_internal ? `CODE_NONE : flash_code),
    .lamp    (red_flash)
  );

  // ==================================================================
  // Output stage, registered
  reg next_safe;
  reg next_diag;
  reg next_yellow;
  reg next_green;
  reg next_red;

  always @* begin
    // Unlocking does not drop outputs; guard opening, upstream loss or a latched error does
    next_safe = g_closed & up_ok & ~err_latched;
    next_diag = g_closed & l_poss & up_ok & ~err_latched & ~warn_any;
    if (!g_closed || err_latched)
      next_yellow = 1'b0;
    else if (g_locked)
      next_yellow = 1'b1;
    else
      next_yellow = blink;
    next_green = up_ok ? 1'b1 : blink;
    if (err_latched && err_internal)
      next_red = 1'b1;
    else
      next_red = red_flash;
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      safety_out_first  <= 1'b0;
      safety_out_second <= 1'b0;
      diag_out          <= 1'b0;
      led_green         <= 1'b0;
      led_yellow        <= 1'b0;
      led_red           <= 1'b0;
    end else if (clk_en) begin
      safety_out_first  <= next_safe;
      safety_out_second <= next_safe;
      diag_out          <= next_diag;
      led_green         <= next_green;
      led_yellow        <= next_yellow;
      led_red           <= next_red;
    end
  end

endmodule

// >>> rtl/guard_lock_defs.vh
`ifndef GUARD_LOCK_DEFS_VH
`define GUARD_LOCK_DEFS_VH

// ====================================================================
// Clock and timing
`define CLK_HZ             40000000
`define ESCALATE_MIN       30
// Sized so the product does not wrap at 32 bits
`define ESCALATE_CYCLES    (40'd60 * `ESCALATE_MIN * `CLK_HZ)
`define FLASH_HALF_MS      250
`define FLASH_HALF_CYCLES  ((`CLK_HZ / 1000) * `FLASH_HALF_MS)
`define FLASH_GAP_PULSES   3

// ====================================================================
// Fault source bit positions in fault_src
`define SRC_OUT_FIRST      0
`define SRC_OUT_SECOND     1
`define SRC_CROSS          2
`define SRC_TEMP           3
`define SRC_ACTUATOR       4
`define SRC_HANDLE         5
`define SRC_INTERNAL       6
`define SRC_W              7

// ====================================================================
// Pulse codes
`define CODE_OUT_FIRST     3'h1
`define CODE_OUT_SECOND    3'h2
`define CODE_CROSS         3'h3
`define CODE_TEMP          3'h4
`define CODE_ACTUATOR      3'h5
`define CODE_HANDLE        3'h6
`define CODE_NONE          3'h0

`endif

// >>> rtl/pulse_code_flasher.v
`timescale 1ns/1ps
`include "guard_lock_defs.vh"

// ====================================================================
// Red indicator pulse-code generator
module pulse_code_flasher #(
  parameter [31:0] HALF_CYCLES = `FLASH_HALF_CYCLES
) (
  input  wire       ref_clk,  // System clock
  input  wire       rst_n,    // Sync reset, active low
  input  wire       clk_en,   // Clock enable
  input  wire [2:0] code,     // Pulses per cycle, 0 = idle
  output reg        lamp      // Flashing lamp drive
);

  localparam [3:0] GAP = `FLASH_GAP_PULSES;

  reg [31:0] tick;
  reg [3:0]  slot;
  reg        phase;
  wire       half_done = (tick == HALF_CYCLES - 32'h1);

  // Each cycle: code pulses then a dark gap of a few pulse slots
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      tick  <= 32'h0;
      slot  <= 4'h0;
      phase <= 1'b0;
      lamp  <= 1'b0;
    end else if (clk_en) begin
      if (code == `CODE_NONE) begin
        tick  <= 32'h0;
        slot  <= 4'h0;
        phase <= 1'b0;
        lamp  <= 1'b0;
      end else if (half_done) begin
        tick  <= 32'h0;
        phase <= ~phase;
        if (phase) begin
          if (slot >= {1'b0, code} + GAP - 4'h1)
            slot <= 4'h0;
          else
            slot <= slot + 4'h1;
        end
        lamp <= ~phase && (slot < {1'b0, code});
      end else begin
        tick <= tick + 32'h1;
      end
    end
  end

endmodule

// >>> tb/guard_lock_fault_monitor_sva.sv
`timescale 1ns/1ps
`include "guard_lock_defs.vh"
// ==========
// Port checker
module guard_lock_fault_monitor_sva #(
  parameter [39:0] ESCALATE_CYCLES = 200,
  parameter [31:0] FLASH_HALF      = 4
) (
  input wire              ref_clk,                   // Clock
  input wire              rst_n,                     // Reset
  input wire              clk_en,                    // Enable
  input wire              guard_closed,              // Guard
  input wire              guard_locked,              // Lock
  input wire              lock_possible,             // Turret
  input wire              upstream_safety_in_first,  // Upstream 1
  input wire              upstream_safety_in_second, // Upstream 2
  input wire [`SRC_W-1:0] fault_src,                 // Faults
  input wire              safety_out_first,          // Safety 1
  input wire              safety_out_second,         // Safety 2
  input wire              diag_out,                  // Diagnostic
  input wire              led_green,                 // Green
  input wire              led_yellow,                // Yellow
  input wire              led_red                    // Red
);
  default clocking @(posedge ref_clk); endclocking
  // Frozen clock enable stalls the pipeline, so no timing holds then
  default disable iff (!rst_n || !clk_en);
  sequence s_off;
    !safety_out_first && !safety_out_second;
  endsequence
  // Error path is two sync stages, latch and output register, hence four edges
  a_internal_off: assert property ($rose(fault_src[`SRC_INTERNAL]) |->
    ##4 (s_off and led_red)) else $error("Internal fault kept outputs on");
  a_actuator_off: assert property ($rose(fault_src[`SRC_ACTUATOR]) |->
    ##4 s_off) else $error("Actuator fault kept outputs on");
  a_handle_off: assert property ($rose(fault_src[`SRC_HANDLE]) |->
    ##4 s_off) else $error("Handle fault kept outputs on");
  a_warn_diag: assert property (fault_src[`SRC_TEMP] |-> ##3 !diag_out)
    else $error("Warning left diagnostic high");
  a_warn_keeps_on: assert property ($rose(fault_src[`SRC_TEMP]) &&
    safety_out_first ##1 guard_closed [*3] |-> safety_out_first)
    else $error("Warning dropped safety output");
  a_open_dark: assert property (!guard_closed |-> ##3 (s_off and
    !diag_out && !led_yellow)) else $error("Open guard left outputs on");
  a_nolock_diag: assert property (!lock_possible |-> ##3 !diag_out)
    else $error("Locking impossible but diagnostic high");
  a_safe_cause: assert property (safety_out_first |->
    $past(guard_closed, 3) && $past(upstream_safety_in_first, 3))
    else $error("Safety output on without cause");
endmodule

bind guard_lock_fault_monitor guard_lock_fault_monitor_sva #(
  .ESCALATE_CYCLES(ESCALATE_CYCLES), .FLASH_HALF(FLASH_HALF)) u_sva (.*);

// >>> tb/plc_model.sv
`timescale 1ns/1ps
// ==========
// Lock actuator driven by the controller command
module plc_model #(
  parameter POWER_TO_LOCK = 0  // Variant select
) (
  input  wire ref_clk,      // Clock
  input  wire lock_cmd,     // Controller command
  output reg  guard_locked  // Bolt engaged
);
  initial guard_locked = 1'b0;
  // Bolt follows one cycle late, like a slow solenoid
  always @(posedge ref_clk) begin
    guard_locked <= POWER_TO_LOCK ? lock_cmd : !lock_cmd;
  end
endmodule

// >>> tb/guard_lock_fault_monitor_tb.sv
`timescale 1ns/1ps
`include "guard_lock_defs.vh"
module guard_lock_fault_monitor_tb;
  localparam ESC = 200;
  localparam H   = 4;
  reg              ref_clk, rst_n, guard_closed, lock_possible;
  reg              in1, in2, lock_cmd, en;
  reg [`SRC_W-1:0] fault_src;
  wire             guard_locked, so1, so2, diag, g, y, r;
  int              num_errors, total_checks, cyc;

  guard_lock_fault_monitor #(.ESCALATE_CYCLES(ESC), .FLASH_HALF(H)) DUT (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(en),
    .guard_closed(guard_closed), .guard_locked(guard_locked),
    .lock_possible(lock_possible), .upstream_safety_in_first(in1),
    .upstream_safety_in_second(in2), .fault_src(fault_src),
    .safety_out_first(so1), .safety_out_second(so2), .diag_out(diag),
    .led_green(g), .led_yellow(y), .led_red(r));
  plc_model u_plc (.ref_clk(ref_clk), .lock_cmd(lock_cmd),
    .guard_locked(guard_locked));

  initial begin
    ref_clk = 0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // ==========
  // Shared tasks
  task w(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task chk(input logic [3:0] got, input logic [3:0] exp);
    #1;
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // A run of 3*H low samples can only be the gap between groups
  task pulses(input logic [3:0] exp);
    int lo, n, k;
    lo = 0;
    n = 0;
    for (k = 0; k < 999 && lo < 3*H; k++) begin
      w(1); #1; lo = (r === 1'b0) ? lo + 1 : 0;
    end
    lo = 1;
    for (k = 0; k < 999 && (n == 0 || lo < 3*H); k++) begin
      w(1); #1;
      if (r === 1'b1 && lo > 0) n++;
      lo = (r === 1'b1) ? 0 : lo + 1;
    end
    chk(n[3:0], exp);
  endtask
  task cycle_guard;
    w(1); guard_closed <= 0; w(6); guard_closed <= 1; w(6);
  endtask
  // ==========
  // Scenarios
  task t_normal;
    logic gs;
    w(1); guard_closed <= 1; in1 <= 1; in2 <= 1; lock_possible <= 1;
    w(6); chk({so1, so2, diag, y}, 4'hf);
    chk(g, 4'h1);
    w(1); lock_cmd <= 1; w(6); chk({so1, so2}, 4'h3);
    gs = y; w(2*H); chk(gs ^ y, 4'h1);
    w(1); lock_possible <= 0; w(5); chk({so1, so2, diag}, 4'h6);
    w(1); lock_possible <= 1; lock_cmd <= 0; guard_closed <= 0;
    w(5); chk({so1, so2, diag, y}, 4'h0);
    w(1); in2 <= 0; guard_closed <= 1; w(5); chk(so1, 4'h0);
    gs = g; w(2*H); chk(gs ^ g, 4'h1);
    w(1); in2 <= 1; w(6); chk({so1, so2, diag}, 4'h7);
    // Clock enable low must freeze the outputs
    w(1); en <= 0; lock_possible <= 0; w(8); chk(diag, 4'h1);
    w(1); en <= 1; w(5); chk(diag, 4'h0);
    w(1); lock_possible <= 1; w(5); chk(diag, 4'h1);
  endtask
  task t_warn(input logic [`SRC_W-1:0] m, input logic [3:0] c);
    w(1); fault_src <= m; w(5); chk({so1, so2, diag}, 4'h6);
    pulses(c);
    w(1); fault_src <= 0; w(5); chk({so1, so2, diag}, 4'h7);
  endtask
  task t_err(input logic [`SRC_W-1:0] m, input logic [3:0] c);
    w(1); fault_src <= m; w(6); chk({so1, so2}, 4'h0);
    if (c == 0) repeat (3) begin
      w(3*H); chk(r, 4'h1);
    end
    else pulses(c);
    cycle_guard; chk({so1, so2}, 4'h0);
    w(1); fault_src <= 0; w(6); chk({so1, so2}, 4'h0);
    cycle_guard; chk({so1, so2, diag}, 4'h7);
  endtask
  task t_escalate;
    w(1); fault_src <= 7'h08; w(150); fault_src <= 0; w(3);
    fault_src <= 7'h08; w(ESC - 10); chk({so1, so2}, 4'h3);
    w(30); chk({so1, so2}, 4'h0);
    pulses(4'h4);
    w(1); fault_src <= 0; w(6); chk({so1, so2}, 4'h0);
    cycle_guard; chk({so1, so2}, 4'h3);
  endtask

  task results;
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      results;
    end
  end
  initial begin
    rst_n = 0; guard_closed = 0; lock_possible = 0;
    in1 = 0; in2 = 0; lock_cmd = 0; fault_src = 0; en = 1;
    w(4); rst_n <= 1;
    t_normal;
    t_warn(7'h01, 4'h1);
    t_warn(7'h02, 4'h2);
    t_warn(7'h03, 4'h3);
    t_warn(7'h04, 4'h3);
    t_warn(7'h08, 4'h4);
    t_err(7'h10, 4'h5);
    t_err(7'h20, 4'h6);
    t_err(7'h40, 4'h0);
    t_escalate;
    results;
  end
endmodule
